// ### common/cie_pkg.sv
// package: constants, register map and carriers of the exception unit
package cie_pkg;

  // ****************************************
  // register map (APB byte addresses)
  // ****************************************
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_TBASE     = 8'h04;
  localparam logic [7:0]  REG_LASTVEC   = 8'h08;
  localparam logic [23:0] TBASE_RESET   = 24'h000000;
  localparam logic [15:0] FLAGS_RESET   = 16'h0002;
  localparam int          FLAG_TF       = 8;
  localparam int          FLAG_IF       = 9;
  localparam int          STAT_NMIACT   = 8;
  localparam int          STAT_NMIPEND  = 9;
  localparam int          STAT_OVRPEND  = 10;
  localparam int          STAT_RESERVED = 11;
  localparam int          STAT_BUSY     = 12;

  // ****************************************
  // vectors
  // ****************************************
  localparam logic [7:0] VEC_DIVIDE   = 8'h00;
  localparam logic [7:0] VEC_STEP     = 8'h01;
  localparam logic [7:0] VEC_NMI      = 8'h02;
  localparam logic [7:0] VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] VEC_RANGE    = 8'h05;
  localparam logic [7:0] VEC_OPCODE   = 8'h06;
  localparam logic [7:0] VEC_NOEXT    = 8'h07;
  localparam logic [7:0] VEC_OVERRUN  = 8'h09;
  localparam logic [7:0] VEC_EXTERR   = 8'h10;
  localparam logic [7:0] VEC_LAST_RSV = 8'h1F;
  localparam int         ENTRY_SHIFT  = 2;

  // ****************************************
  // request slots, highest priority first
  // ****************************************
  localparam int REQ_DIVIDE   = 0;
  localparam int REQ_RANGE    = 1;
  localparam int REQ_OPCODE   = 2;
  localparam int REQ_NOEXT    = 3;
  localparam int REQ_EXTERR   = 4;
  localparam int REQ_OVERFLOW = 5;
  localparam int REQ_STEP     = 6;
  localparam int REQ_NMI      = 7;
  localparam int REQ_OVERRUN  = 8;
  localparam int REQ_MASKABLE_IRQ_IN     = 9;
  localparam int REQ_SOFT     = 10;
  localparam int REQ_COUNT    = 11;
  localparam int FAULT_LAST   = 4;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_CHECK  = 7'b0000010,
    ST_ACK    = 7'b0000100,
    ST_FLAGS  = 7'b0001000,
    ST_PUSHCS = 7'b0010000,
    ST_PUSHIP = 7'b0100000,
    ST_LOAD   = 7'b1000000
  } cie_state_t;

  // frame of the interrupt being entered
  typedef struct packed {
    logic [7:0]  vector;
    logic [15:0] retCs;
    logic [15:0] retIp;
  } cie_frame_t;

  // per-instruction events from the core, valid with instrDone
  typedef struct packed {
    logic       divideErr;
    logic       rangeErr;
    logic       badOpcode;
    logic       noExtension;
    logic       extError;
    logic       overflowTrap;
    logic       softInt;
    logic [7:0] softVector;
  } cie_events_t;

endpackage : cie_pkg

// ### logic/cie_prio_arb.sv
// fixed-priority one-hot arbiter, lowest index wins
`timescale 1ns/1ps
module cie_prio_arb #(
  parameter int N = 11
) (
  // requests and grant
  input  wire logic [N-1:0] req,
  output logic      [N-1:0] grant,
  output logic              any
);

  logic [N:0] blocked;

  assign blocked[0] = 1'b0;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_slot
      assign grant[i]     = req[i] & ~blocked[i];
      assign blocked[i+1] = blocked[i] | req[i];
    end
  endgenerate

  assign any = blocked[N];

endmodule : cie_prio_arb

// ### logic/cie_exc_unit.sv
// interrupt and exception entry sequencer with APB status port
`timescale 1ns/1ps
module cie_exc_unit #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // external pins
  input  wire logic                maskable_irq_in,
  input  wire logic                nmiIn,
  input  wire logic                extOverrunIn,
  output logic                     intAck,
  input  wire logic                ackValidIn,
  input  wire logic [7:0]          ackVectorIn,
  // core instruction boundary
  input  wire logic                instrDone,
  input  wire cie_pkg::cie_events_t events,
  input  wire logic [15:0]         codeSeg,
  input  wire logic [15:0]         instrStartIp,
  input  wire logic [15:0]         instr_pointer,
  // core flag updates
  input  wire logic                flagsWrite,
  input  wire logic [15:0]         flagsIn,
  input  wire logic                interrupt_return_op,
  input  wire logic [15:0]         returnFlags,
  output logic      [15:0]         flagsOut,
  // stack pushes and handler load
  output logic                     coreHold,
  output logic                     pushValid,
  output logic      [15:0]         pushData,
  output logic                     loadReq,
  output logic      [23:0]         tableAddr,
  input  wire logic                loadDone,
  input  wire logic [15:0]         handlerCs,
  input  wire logic [15:0]         handlerIp
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0]  syncA;
  logic [3:0]  syncB;
  logic [7:0]  vecA;
  logic [7:0]  vecB;
  logic        nmiPrev;
  logic        ovrPrev;
  wire  logic  irqS   = syncB[0];
  wire  logic  nmiS   = syncB[1];
  wire  logic  ovrS   = syncB[2];
  wire  logic  ackS   = syncB[3];
  wire  logic  nmiEdge = nmiS & ~nmiPrev;
  wire  logic  ovrEdge = ovrS & ~ovrPrev;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA   <= 4'h0;
      syncB   <= 4'h0;
      vecA    <= 8'h00;
      vecB    <= 8'h00;
      nmiPrev <= 1'b0;
      ovrPrev <= 1'b0;
    end else begin
      syncA   <= {ackValidIn, extOverrunIn, nmiIn, maskable_irq_in};
      syncB   <= syncA;
      vecA    <= ackVectorIn;
      vecB    <= vecA;
      nmiPrev <= nmiS;
      ovrPrev <= ovrS;
    end
  end

  // ****************************************
  // state and held requests
  // ****************************************
  cie_pkg::cie_state_t state;
  cie_pkg::cie_state_t next_state;
  cie_pkg::cie_frame_t frame;
  logic [15:0] flags;
  logic [15:0] savedFlags;
  logic [6:0]  evHeld;
  logic [7:0]  softVec;
  logic        softPending;
  logic [15:0] retStart;
  logic [15:0] retNext;
  logic [15:0] retCs;
  logic        nmiPend;
  logic        nmiActive;
  logic        ovrPend;
  logic [23:0] tableBase;
  logic [7:0]  lastVec;
  logic        rsvHit;
  logic [cie_pkg::REQ_COUNT-1:0] req;
  logic [cie_pkg::REQ_COUNT-1:0] grant;
  logic                          anyReq;

  wire logic inCheck  = (state == cie_pkg::ST_CHECK);
  wire logic inAck    = (state == cie_pkg::ST_ACK);
  wire logic inFlags  = (state == cie_pkg::ST_FLAGS);
  wire logic inLoad   = (state == cie_pkg::ST_LOAD);
  wire logic takeIdle = (state == cie_pkg::ST_IDLE) & instrDone;
  wire logic takeAck  = inAck & ackS;
  wire logic ifSet    = flags[cie_pkg::FLAG_IF];
  // hardware requests are looked at only in CHECK, i.e. at a boundary
  wire logic nmiOk    = nmiPend & ~nmiActive;
  wire logic ovrOk    = ovrPend & ~nmiActive;
  wire logic intrOk   = irqS & ifSet & ~nmiActive & ~nmiPend & ~ackS;

  assign req[cie_pkg::REQ_DIVIDE]   = evHeld[0];
  assign req[cie_pkg::REQ_RANGE]    = evHeld[1];
  assign req[cie_pkg::REQ_OPCODE]   = evHeld[2];
  assign req[cie_pkg::REQ_NOEXT]    = evHeld[3];
  assign req[cie_pkg::REQ_EXTERR]   = evHeld[4];
  assign req[cie_pkg::REQ_OVERFLOW] = evHeld[5];
  assign req[cie_pkg::REQ_STEP]     = evHeld[6];
  assign req[cie_pkg::REQ_NMI]      = nmiOk;
  assign req[cie_pkg::REQ_OVERRUN]  = ovrOk;
  assign req[cie_pkg::REQ_MASKABLE_IRQ_IN]     = intrOk;
  // pending flag only: a held vector must not re-request after the grant
  assign req[cie_pkg::REQ_SOFT]     = softPending;

  // fixed processing order by slot index
  cie_prio_arb #(
    .N (cie_pkg::REQ_COUNT)
  ) u_arb (
    .req   (req),
    .grant (grant),
    .any   (anyReq)
  );

  // ****************************************
  // vector and return address of the winner
  // ****************************************
  logic [7:0]  winVec;
  logic        winFault;

  always_comb begin
    winVec   = softVec;
    winFault = 1'b0;
    if (grant[cie_pkg::REQ_DIVIDE]) begin
      winVec   = cie_pkg::VEC_DIVIDE;
      winFault = 1'b1;
    end else if (grant[cie_pkg::REQ_RANGE]) begin
      winVec   = cie_pkg::VEC_RANGE;
      winFault = 1'b1;
    end else if (grant[cie_pkg::REQ_OPCODE]) begin
      winVec   = cie_pkg::VEC_OPCODE;
      winFault = 1'b1;
    end else if (grant[cie_pkg::REQ_NOEXT]) begin
      winVec   = cie_pkg::VEC_NOEXT;
      winFault = 1'b1;
    end else if (grant[cie_pkg::REQ_EXTERR]) begin
      winVec   = cie_pkg::VEC_EXTERR;
      winFault = 1'b1;
    end else if (grant[cie_pkg::REQ_OVERFLOW]) begin
      winVec   = cie_pkg::VEC_OVERFLOW;
    end else if (grant[cie_pkg::REQ_STEP]) begin
      winVec   = cie_pkg::VEC_STEP;
    end else if (grant[cie_pkg::REQ_NMI]) begin
      winVec   = cie_pkg::VEC_NMI;
    end else if (grant[cie_pkg::REQ_OVERRUN]) begin
      winVec   = cie_pkg::VEC_OVERRUN;
    end
  end

  // faults resume at the first prefix byte, traps past the instruction
  wire logic [15:0] winRetIp = winFault ? retStart : retNext;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    case (state)
      cie_pkg::ST_IDLE:   next_state = instrDone ? cie_pkg::ST_CHECK : cie_pkg::ST_IDLE;
      cie_pkg::ST_CHECK: begin
        if (!anyReq)
          next_state = cie_pkg::ST_IDLE;
        else if (grant[cie_pkg::REQ_MASKABLE_IRQ_IN])
          next_state = cie_pkg::ST_ACK;
        else
          next_state = cie_pkg::ST_FLAGS;
      end
      cie_pkg::ST_ACK:    next_state = ackS ? cie_pkg::ST_FLAGS : cie_pkg::ST_ACK;
      cie_pkg::ST_FLAGS:  next_state = cie_pkg::ST_PUSHCS;
      cie_pkg::ST_PUSHCS: next_state = cie_pkg::ST_PUSHIP;
      cie_pkg::ST_PUSHIP: next_state = cie_pkg::ST_LOAD;
      // back to CHECK so a newly pending request nests first
      cie_pkg::ST_LOAD:   next_state = loadDone ? cie_pkg::ST_CHECK : cie_pkg::ST_LOAD;
      default:            next_state = cie_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= cie_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // held instruction events; a granted slot clears only its own bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evHeld      <= 7'h00;
      softVec     <= 8'h00;
      softPending <= 1'b0;
    end else if (takeIdle) begin
      evHeld      <= {flags[cie_pkg::FLAG_TF], events.overflowTrap, events.extError,
                      events.noExtension, events.badOpcode, events.rangeErr,
                      events.divideErr};
      softVec     <= events.softVector;
      softPending <= events.softInt;
    end else if (inCheck) begin
      evHeld      <= evHeld & ~grant[6:0];
      softPending <= softPending & ~grant[cie_pkg::REQ_SOFT];
    end
  end

  // frame capture: boundary, then winner, then acknowledge vector
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      retStart <= 16'h0000;
      retNext  <= 16'h0000;
      retCs    <= 16'h0000;
      frame    <= '0;
    end else if (takeIdle) begin
      retStart <= instrStartIp;
      retNext  <= instr_pointer;
      retCs    <= codeSeg;
    end else if (inLoad && loadDone) begin
      retStart <= handlerIp;
      retNext  <= handlerIp;
      retCs    <= handlerCs;
    end else if (inCheck && anyReq) begin
      frame <= '{vector: winVec, retCs: retCs, retIp: winRetIp};
    end else if (takeAck) begin
      frame.vector <= vecB;
    end
  end

  // ****************************************
  // nmi tracking and latched pin events
  // ****************************************
  wire logic nmiTaken = inCheck & grant[cie_pkg::REQ_NMI];
  wire logic ovrTaken = inCheck & grant[cie_pkg::REQ_OVERRUN];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nmiPend   <= 1'b0;
      nmiActive <= 1'b0;
      ovrPend   <= 1'b0;
    end else begin
      // a fresh edge in the taking cycle wins over the clear
      nmiPend   <= nmiEdge | (nmiPend & ~nmiTaken);
      ovrPend   <= ovrEdge | (ovrPend & ~ovrTaken);
      if (nmiTaken)
        nmiActive <= 1'b1;
      else if (interrupt_return_op)
        nmiActive <= 1'b0;
    end
  end

  // ****************************************
  // flag word
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags      <= cie_pkg::FLAGS_RESET;
      savedFlags <= cie_pkg::FLAGS_RESET;
    end else if (inFlags) begin
      savedFlags                <= flags;
      flags[cie_pkg::FLAG_IF]   <= 1'b0;
      flags[cie_pkg::FLAG_TF]   <= 1'b0;
    end else if (interrupt_return_op) begin
      flags <= returnFlags;
    end else if (flagsWrite) begin
      flags <= flagsIn;
    end
  end

  // ****************************************
  // core side outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pushValid <= 1'b0;
      pushData  <= 16'h0000;
    end else begin
      pushValid <= inFlags | (state == cie_pkg::ST_PUSHCS) | (state == cie_pkg::ST_PUSHIP);
      if (inFlags)
        pushData <= flags;
      else if (state == cie_pkg::ST_PUSHCS)
        pushData <= frame.retCs;
      else if (state == cie_pkg::ST_PUSHIP)
        pushData <= frame.retIp;
    end
  end

  assign coreHold  = (state != cie_pkg::ST_IDLE);
  assign intAck    = inAck;
  assign loadReq   = inLoad;
  assign flagsOut  = flags;
  // one pointer per vector, so up to 256 four-byte entries
  assign tableAddr = tableBase + {14'h0000, frame.vector, 2'b00};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lastVec <= 8'h00;
      rsvHit  <= 1'b0;
    end else if (inFlags) begin
      lastVec <= frame.vector;
      rsvHit  <= frame.vector <= cie_pkg::VEC_LAST_RSV;
    end
  end

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  wire logic hitStatus = paddr == ADDR_W'(cie_pkg::REG_STATUS);
  wire logic hitBase   = paddr == ADDR_W'(cie_pkg::REG_TBASE);
  wire logic hitLast   = paddr == ADDR_W'(cie_pkg::REG_LASTVEC);
  wire logic mapped    = hitStatus | hitBase | hitLast;
  wire logic setup     = psel & ~penable;
  wire logic [31:0] statusWord = {19'h00000, coreHold, rsvHit, ovrPend, nmiPend,
                                  nmiActive, savedFlags[7:0]};
  wire logic [31:0] rdMux = hitStatus ? statusWord :
                            hitBase   ? {8'h00, tableBase} :
                            hitLast   ? {24'h000000, lastVec} : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata    <= 32'h00000000;
      tableBase <= cie_pkg::TBASE_RESET;
    end else begin
      if (setup)
        prdata <= rdMux;
      if (psel && penable && pwrite && hitBase)
        tableBase <= pwdata[23:0];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_entry;
    state == cie_pkg::ST_FLAGS ##1 state == cie_pkg::ST_PUSHCS
      ##1 state == cie_pkg::ST_PUSHIP ##1 state == cie_pkg::ST_LOAD;
  endsequence

  a_push_order: assert property (@(posedge sys_clk) disable iff (rst)
    inFlags |-> s_entry) else $error("entry sequence broken");
  a_push_flags: assert property (@(posedge sys_clk) disable iff (rst)
    inFlags |=> pushValid && pushData == $past(flags)) else $error("flags not pushed");
  a_if_cleared: assert property (@(posedge sys_clk) disable iff (rst)
    inFlags |=> !flags[cie_pkg::FLAG_IF] && !flags[cie_pkg::FLAG_TF]) else $error("if not cleared");
  a_ack_gated: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(inAck) |-> $past(ifSet) && !$past(nmiPend)) else $error("ack while masked");
  a_nmi_noack: assert property (@(posedge sys_clk) disable iff (rst)
    nmiTaken |=> inFlags ##1 frame.vector == cie_pkg::VEC_NMI) else $error("nmi path wrong");
  a_nmi_block: assert property (@(posedge sys_clk) disable iff (rst)
    inCheck && nmiActive |-> (!grant[cie_pkg::REQ_NMI] && !grant[cie_pkg::REQ_MASKABLE_IRQ_IN]
      && !grant[cie_pkg::REQ_OVERRUN]) ##1 !inAck) else $error("blocked request taken");
  a_table_addr: assert property (@(posedge sys_clk) disable iff (rst)
    inLoad |-> tableAddr == tableBase + 24'(frame.vector) * 24'd4) else $error("bad entry");
  a_fault_ret: assert property (@(posedge sys_clk) disable iff (rst)
    inCheck && grant[cie_pkg::REQ_OPCODE] |=> frame.retIp == $past(retStart)
      && frame.vector == cie_pkg::VEC_OPCODE) else $error("fault return wrong");
  a_ovf_trap: assert property (@(posedge sys_clk) disable iff (rst)
    inCheck && grant[cie_pkg::REQ_OVERFLOW] |=> frame.retIp == $past(retNext)
      && frame.vector == cie_pkg::VEC_OVERFLOW) else $error("overflow trap wrong");
  a_step_vec: assert property (@(posedge sys_clk) disable iff (rst)
    inCheck && grant[cie_pkg::REQ_STEP] |=> frame.vector == cie_pkg::VEC_STEP) else $error("step");

endmodule : cie_exc_unit

// ### dv/cie_ctl_model.sv
// interrupt controller model answering the acknowledge sequence
`timescale 1ns/1ps
module cie_ctl_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // acknowledge handshake
  input  wire logic       intAck,
  input  wire logic       slow,
  input  wire logic [7:0] vec,
  output logic            ackValidIn,
  output logic      [7:0] ackVectorIn
);
  logic [2:0] waitCnt;
  // vector lines toggle while not valid, so a stale vector never passes
  always @(posedge sys_clk) begin
    if (rst || intAck !== 1'b1 || waitCnt < (slow ? 3'h6 : 3'h1)) begin
      waitCnt     <= (rst || intAck !== 1'b1) ? 3'h0 : waitCnt + 3'h1;
      ackValidIn  <= 1'b0;
      ackVectorIn <= rst ? 8'hA5 : ~ackVectorIn;
    end else begin
      ackValidIn  <= 1'b1;
      ackVectorIn <= vec;
    end
  end
endmodule : cie_ctl_model

// ### dv/tb.sv
// self-checking bench of the exception unit
`timescale 1ns/1ps
module tb;
  logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        irq = 1'b0, nmiIn = 1'b0, ovr = 1'b0, instrDone = 1'b0, slow = 1'b0;
  logic        flagsWrite = 1'b0, retOp = 1'b0, loadDone = 1'b0, ackSeen = 1'b0, err;
  logic        pready, pslverr, intAck, ackValidIn, coreHold, pushValid, loadReq;
  logic [7:0]  paddr = 8'h00, ackVectorIn, vec = 8'h20;
  logic [15:0] cs = 16'h0, sip = 16'h0, nip = 16'h0, fIn = 16'h0, rf = 16'h0;
  logic [15:0] flagsOut, pushData;
  logic [23:0] tableAddr, base;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] pushQ[$];
  logic [23:0] addrQ[$];
  logic [7:0]  fv[6] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h10, 8'h04};
  cie_pkg::cie_events_t ev = '0;
  integer      fails = 0, checked = 0, seed = 94889, i;

  always #2.5 sys_clk = ~sys_clk;

  cie_exc_unit dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .maskable_irq_in(irq), .nmiIn(nmiIn), .extOverrunIn(ovr),
    .intAck(intAck), .ackValidIn(ackValidIn), .ackVectorIn(ackVectorIn),
    .instrDone(instrDone), .events(ev), .codeSeg(cs), .instrStartIp(sip),
    .instr_pointer(nip), .flagsWrite(flagsWrite), .flagsIn(fIn),
    .interrupt_return_op(retOp), .returnFlags(rf), .flagsOut(flagsOut),
    .coreHold(coreHold), .pushValid(pushValid), .pushData(pushData), .loadReq(loadReq),
    .tableAddr(tableAddr), .loadDone(loadDone), .handlerCs(16'hF00D), .handlerIp(16'h0100));
  cie_ctl_model ctl (.sys_clk(sys_clk), .rst(rst), .intAck(intAck), .slow(slow), .vec(vec),
    .ackValidIn(ackValidIn), .ackVectorIn(ackVectorIn));

  // ****************
  // core side: loads handler one cycle after the request, logs pushes
  // ****************
  always @(posedge sys_clk) begin
    loadDone <= (loadReq === 1'b1) && !loadDone;
    if (loadReq === 1'b1 && !loadDone) addrQ.push_back(tableAddr);
    if (pushValid === 1'b1) pushQ.push_back(pushData);
    if (intAck === 1'b1) ackSeen <= 1'b1;
  end

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  function automatic logic [23:0] slot(input logic [7:0] v);
    return base + {14'h0, v, 2'b00};
  endfunction : slot

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (++n > 20) begin
        chk(1'b0, "apb hang");
        tally_and_finish();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setf(input logic [15:0] f);
    @(posedge sys_clk);
    flagsWrite <= 1'b1;
    fIn <= f;
    @(posedge sys_clk);
    flagsWrite <= 1'b0;
  endtask : setf

  task automatic edgeIn(input logic o);
    @(posedge sys_clk);
    nmiIn <= 1'b1;
    ovr <= o;
    repeat (3) @(posedge sys_clk);
    nmiIn <= 1'b0;
    ovr <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : edgeIn

  task automatic entry(input logic [7:0] v, input logic atStart, input logic [15:0] f,
                       input logic [14:0] e);
    integer n;
    n = 0;
    pushQ.delete();
    addrQ.delete();
    @(posedge sys_clk);
    instrDone <= 1'b1;
    ev <= cie_pkg::cie_events_t'(e);
    cs <= 16'($random(seed));
    sip <= 16'($random(seed));
    nip <= 16'($random(seed));
    @(posedge sys_clk);
    instrDone <= 1'b0;
    ev <= '0;
    @(negedge sys_clk);
    while (coreHold !== 1'b0) begin
      @(negedge sys_clk);
      if (++n > 200) begin
        chk(1'b0, "entry hang");
        tally_and_finish();
      end
    end
    chk(addrQ.size() > 0 && addrQ[0] === slot(v), "handler slot");
    chk(pushQ.size() > 2 && pushQ[0] === f && pushQ[1] === cs, "flags or segment");
    chk(pushQ.size() > 2 && pushQ[2] === (atStart ? sip : nip), "return offset");
    chk(flagsOut[cie_pkg::FLAG_IF] === 1'b0, "enable left set");
  endtask : entry

  task automatic quiet(input string msg);
    pushQ.delete();
    @(posedge sys_clk);
    instrDone <= 1'b1;
    @(posedge sys_clk);
    instrDone <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(pushQ.size() == 0 && coreHold === 1'b0, msg);
  endtask : quiet

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(flagsOut === cie_pkg::FLAGS_RESET && coreHold === 1'b0, "reset state");
    apb(1'b0, cie_pkg::REG_TBASE, 32'h0);
    chk(rd === 32'h0, "table base reset");
    base = 24'($random(seed));
    apb(1'b1, cie_pkg::REG_TBASE, {8'h00, base});
    apb(1'b0, cie_pkg::REG_TBASE, 32'h0);
    chk(rd === {8'h00, base} && err === 1'b0, "table base readback");
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped access");
    for (i = 0; i < 6; i++) begin
      setf(16'h0A02);
      entry(fv[i], i < 5, 16'h0A02, 15'h4000 >> i);
      apb(1'b0, cie_pkg::REG_STATUS, 32'h0);
      chk(rd[cie_pkg::STAT_RESERVED] === 1'b1 && rd[7:0] === 8'h02, "reserved flag");
    end
    for (i = 0; i < 4; i++) begin
      vec = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      setf(16'h0202);
      entry(vec, 1'b0, 16'h0202, {7'h01, vec});
    end
    setf(16'h0302);
    entry(cie_pkg::VEC_STEP, 1'b0, 16'h0302, 15'h0000);
    chk(flagsOut[cie_pkg::FLAG_TF] === 1'b0, "step flag kept");
    setf(16'h0302);
    entry(cie_pkg::VEC_OPCODE, 1'b1, 16'h0302, 15'h1140);
    chk(addrQ.size() > 1 && addrQ[addrQ.size()-1] === slot(8'h40), "soft not last");
    setf(16'h0002);
    irq <= 1'b1;
    quiet("masked request taken");
    for (i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      slow <= i[0];
      vec <= 8'h20 + 8'($random(seed)) % 8'hE0;
      setf(16'h0202);
      entry(vec, 1'b0, 16'h0202, 15'h0000);
      apb(1'b0, cie_pkg::REG_LASTVEC, 32'h0);
      chk(rd === {24'h000000, vec}, "last vector");
      apb(1'b0, cie_pkg::REG_STATUS, 32'h0);
      chk(rd[cie_pkg::STAT_RESERVED] === 1'b0, "user vector flagged reserved");
    end
    chk(ackSeen === 1'b1, "no acknowledge");
    ackSeen <= 1'b0;
    setf(16'h0202);
    edgeIn(1'b0);
    entry(cie_pkg::VEC_NMI, 1'b0, 16'h0202, 15'h0000);
    chk(ackSeen === 1'b0 && addrQ.size() == 1, "nmi ran acknowledge");
    apb(1'b0, cie_pkg::REG_STATUS, 32'h0);
    chk(rd[cie_pkg::STAT_NMIACT] === 1'b1, "nmi service not flagged");
    edgeIn(1'b1);
    setf(16'h0202);
    quiet("taken during nmi service");
    apb(1'b0, cie_pkg::REG_STATUS, 32'h0);
    chk(rd[cie_pkg::STAT_NMIPEND] === 1'b1 && rd[cie_pkg::STAT_OVRPEND] === 1'b1, "not held");
    @(posedge sys_clk);
    irq <= 1'b0;
    rf <= 16'h0102;
    retOp <= 1'b1;
    @(posedge sys_clk);
    retOp <= 1'b0;
    @(negedge sys_clk);
    chk(flagsOut === 16'h0102, "flags not restored");
    entry(cie_pkg::VEC_STEP, 1'b0, 16'h0102, 15'h0000);
    chk(addrQ.size() == 2 && addrQ[1] === slot(cie_pkg::VEC_NMI), "held nmi lost");
    tally_and_finish();
  end
endmodule : tb
